// ### rtl/smb_pkg.sv
// package of constants and types for the mode and burst order logic
package smb_pkg;

  // ----------------------------------------------------------------
  // command pin encodings and widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;                 // address pins a0..a13
  localparam int DATA_W = 8;                  // data pins per beat
  localparam int BEATS = 8;                   // beats in a full burst
  localparam int FIFO_DEPTH = 8;              // write beat buffer depth
  localparam logic [2:0] BANK_FIRST_MR = 3'h0;  // bank code of the first mode register
  localparam logic [2:0] BANK_SECOND_MR = 3'h1; // bank code, bank_bit_zero high

  // ----------------------------------------------------------------
  // first mode register field positions
  // ----------------------------------------------------------------
  localparam int MR0_BL_LSB = 0;              // burst length field a0..a1
  localparam int MR0_BT_BIT = 3;              // burst type, 1 = interleaved
  localparam int MR0_DLL_RST_BIT = 8;         // self-clearing dll reset
  localparam int MR0_WR_LSB = 9;              // write recovery a9..a11
  localparam int MR0_PD_FAST_BIT = 12;        // precharge power-down fast exit

  // burst length field codes
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0; // burst_eight_beats always
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;  // chosen by burst_chop_n
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;  // burst_chop_four always

  // ----------------------------------------------------------------
  // second mode register field positions
  // ----------------------------------------------------------------
  localparam int MR1_DLL_DIS_BIT = 0;         // 0 = dll enabled
  localparam int MR1_DRV_LO_BIT = 1;          // drive strength low bit
  localparam int MR1_DRV_HI_BIT = 5;          // drive strength high bit
  localparam int MR1_WLVL_BIT = 7;            // write leveling enable
  localparam int MR1_QOFF_BIT = 12;           // output disconnect

  // reset values of both registers
  localparam logic [ADDR_W-1:0] MR0_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] MR1_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // timing: internal write start after a write command
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;        // 250 MHz clock
  localparam int WR_START_PS = 24000;         // eight-beat internal write start
  localparam int WR_PULL_IN = 2;              // fixed chop starts this much earlier
  localparam int WR_START_CYC = (WR_START_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] WR_START_EIGHT = 4'(WR_START_CYC);
  localparam logic [3:0] WR_START_CHOP = 4'(WR_START_CYC - WR_PULL_IN);

  // burst engine states, gray along idle -> read and idle -> write
  typedef enum logic [1:0] {
    SMB_IDLE = 2'b00,
    SMB_READ = 2'b01,
    SMB_WRITE = 2'b10
  } smb_state_t;

endpackage : smb_pkg

// ### rtl/smb_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_ff [DEPTH];           // word storage
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;       // fill pointer
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;       // drain pointer
  logic [AW:0] count_ff, nxt_count;           // words held
  logic push, pop;

  // honest full and empty from the word count
  assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  // next pointer values
  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    nxt_wr_ptr = push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
    nxt_rd_ptr = pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
    nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  // pointer registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end
endmodule : smb_fifo
`default_nettype wire

// ### rtl/smb_mode_burst.sv
// mode registers, burst ordering and data beat engine of the dram
`timescale 1ns/1ps
`default_nettype none
module smb_mode_burst
  import smb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cs_n_in,                   // chip select, active low
  input wire logic ras_n_in,                  // row strobe, active low
  input wire logic cas_n_in,                  // column strobe, active low
  input wire logic we_n_in,                   // write enable, active low
  input wire logic [2:0] bank_in,             // bank address pins
  input wire logic [ADDR_W-1:0] addr_in,      // address pins
  input wire logic self_refresh_in,           // device is in self-refresh
  input wire logic precharge_pd_in,           // device is in precharge power-down
  input wire logic [DATA_W-1:0] wr_data_in,   // write beat from the data pins
  input wire logic wr_valid_in,               // write beat present
  output logic wr_ready_out,                  // write beat buffer has room
  output logic [DATA_W-1:0] dq_out,           // read data beat
  output logic dq_oe_out,                     // data drivers on
  output logic dqs_out,                       // read strobe level
  output logic dqs_oe_out,                    // strobe drivers on
  output logic [2:0] beat_col_out,            // column of the current beat
  output logic interleaved_out,               // burst type in use
  output logic [1:0] burst_len_sel_out,       // burst length field
  output logic dll_reset_pulse_out,           // dll reset carried out
  output logic dll_running_out,               // dll clock is active
  output logic [2:0] write_recovery_out,      // write recovery field
  output logic pd_fast_exit_out,              // fast power-down exit selected
  output logic [1:0] drive_strength_out,      // output impedance select
  output logic write_leveling_out,            // write leveling mode on
  output logic outputs_off_out,               // output drivers disconnected
  output logic internal_write_start_out       // internal write begins
);

  // ----------------------------------------------------------------
  // command decode and burst order helpers
  // ----------------------------------------------------------------

  // true for a mode register set aimed at the given bank code
  function automatic logic is_mrs(input logic cs_n, input logic ras_n, input logic cas_n,
                                  input logic we_n, input logic [2:0] bank,
                                  input logic [2:0] code);
    is_mrs = !cs_n && !ras_n && !cas_n && !we_n && (bank == code);
  endfunction : is_mrs

  // column of beat idx for a given start column and burst type
  function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] idx,
                                          input logic ilv);
    if (ilv) begin
      beat_col = start ^ idx;
    end else begin
      beat_col = {start[2] ^ idx[2], 2'(start[1:0] + idx[1:0])};
    end
  endfunction : beat_col

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] mr0_ff, nxt_mr0;         // first_mode_register
  logic [ADDR_W-1:0] mr1_ff, nxt_mr1;         // second_mode_register
  logic dll_pulse_ff, nxt_dll_pulse;          // dll reset carried out
  smb_state_t state_ff, nxt_state;            // burst engine state
  logic [2:0] beat_ff, nxt_beat;              // beat index in burst
  logic [2:0] start_ff, nxt_start;            // start column of burst
  logic chop_ff, nxt_chop;                    // current burst is chopped
  logic ilv_ff, nxt_ilv;                      // interleaved for this burst
  logic [3:0] wr_cnt_ff, nxt_wr_cnt;          // cycles to internal write
  logic [DATA_W-1:0] dq_ff, nxt_dq;           // registered read data
  logic dq_oe_ff, nxt_dq_oe;                  // registered data enable
  logic dqs_ff, nxt_dqs;                      // registered strobe level
  logic [2:0] col_ff, nxt_col;                // registered beat column
  logic iws_ff, nxt_iws;                      // internal write start pulse
  logic [DATA_W-1:0] line_ff [BEATS];         // one burst of stored data

  // write side of the stored line
  logic line_we;
  logic [2:0] line_addr;

  // fifo drain side
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  // decoded commands
  logic cmd_mrs0, cmd_mrs1, cmd_read, cmd_write, cmd_chop;

  // ----------------------------------------------------------------
  // write beat buffer
  // ----------------------------------------------------------------
  smb_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_data_in(wr_data_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb begin
    cmd_mrs0 = is_mrs(cs_n_in, ras_n_in, cas_n_in, we_n_in, bank_in, BANK_FIRST_MR);
    cmd_mrs1 = is_mrs(cs_n_in, ras_n_in, cas_n_in, we_n_in, bank_in, BANK_SECOND_MR);
    cmd_read = !cs_n_in && ras_n_in && !cas_n_in && we_n_in;
    cmd_write = !cs_n_in && ras_n_in && !cas_n_in && !we_n_in;
    // length choice per command
    case (mr0_ff[MR0_BL_LSB +: 2])
      BL_FIXED_CHOP: cmd_chop = 1'b1;
      BL_ON_THE_FLY: cmd_chop = !addr_in[12];
      default: cmd_chop = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // mode registers and dll reset
  // ----------------------------------------------------------------

  // load on set commands, dll reset bit self-clears a cycle later
  always_comb begin
    nxt_mr0 = mr0_ff;
    nxt_mr1 = mr1_ff;
    nxt_dll_pulse = 1'b0;
    if (mr0_ff[MR0_DLL_RST_BIT]) begin
      nxt_mr0[MR0_DLL_RST_BIT] = 1'b0;
      nxt_dll_pulse = 1'b1;
    end
    if (cmd_mrs0) begin
      nxt_mr0 = addr_in;
    end
    if (cmd_mrs1) begin
      nxt_mr1 = addr_in;
    end
  end

  // mode register flops
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mr0_ff <= MR0_RESET;
      mr1_ff <= MR1_RESET;
      dll_pulse_ff <= 1'b0;
    end else begin
      mr0_ff <= nxt_mr0;
      mr1_ff <= nxt_mr1;
      dll_pulse_ff <= nxt_dll_pulse;
    end
  end

  // ----------------------------------------------------------------
  // burst engine
  // ----------------------------------------------------------------

  // sequences read beats from the line and write beats into it
  always_comb begin
    nxt_state = state_ff;
    nxt_beat = beat_ff;
    nxt_start = start_ff;
    nxt_chop = chop_ff;
    nxt_ilv = ilv_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = 1'b0;
    nxt_dqs = 1'b0;
    nxt_col = col_ff;
    nxt_wr_cnt = wr_cnt_ff;
    nxt_iws = 1'b0;
    fifo_pop = 1'b0;
    line_we = 1'b0;
    line_addr = 3'h0;
    // internal write timer runs beside the engine
    if (wr_cnt_ff != 4'h0) begin
      nxt_wr_cnt = wr_cnt_ff - 4'h1;
      nxt_iws = (wr_cnt_ff == 4'h1);
    end
    case (state_ff)
      SMB_IDLE: begin
        if (cmd_read) begin
          nxt_state = SMB_READ;
          nxt_beat = 3'h0;
          nxt_start = addr_in[2:0];
          nxt_chop = cmd_chop;
          nxt_ilv = mr0_ff[MR0_BT_BIT];
        end else if (cmd_write) begin
          nxt_state = SMB_WRITE;
          nxt_beat = 3'h0;
          // chopped writes keep only a2, eight-beat writes none
          nxt_start = cmd_chop ? {addr_in[2], 2'b00} : 3'h0;
          nxt_chop = cmd_chop;
          // only fixed chop pulls the internal write in
          if (mr0_ff[MR0_BL_LSB +: 2] == BL_FIXED_CHOP) begin
            nxt_wr_cnt = WR_START_CHOP;
          end else begin
            nxt_wr_cnt = WR_START_EIGHT;
          end
        end
      end
      SMB_READ: begin
        nxt_col = beat_col(start_ff, beat_ff, ilv_ff);
        nxt_dq = line_ff[nxt_col];
        nxt_dqs = !beat_ff[0];
        // chop leaves the last four slots undriven
        nxt_dq_oe = !(chop_ff && beat_ff[2]) && !mr1_ff[MR1_QOFF_BIT];
        nxt_beat = beat_ff + 3'h1;
        if (beat_ff == 3'h7) begin
          nxt_state = SMB_IDLE;
        end
      end
      SMB_WRITE: begin
        // each beat waits for the buffer, so the buffer drains
        fifo_pop = 1'b1;
        if (fifo_valid) begin
          line_addr = start_ff + {1'b0, beat_ff[1:0]};
          if (chop_ff) begin
            line_addr = {start_ff[2], beat_ff[1:0]};
          end else begin
            line_addr = beat_ff;
          end
          // last four chopped beats are dropped
          line_we = !(chop_ff && beat_ff[2]);
          nxt_col = line_addr;
          nxt_beat = beat_ff + 3'h1;
          if (beat_ff == 3'h7) begin
            nxt_state = SMB_IDLE;
          end
        end
      end
      default: begin
        nxt_state = SMB_IDLE;
      end
    endcase
  end

  // burst engine flops
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= SMB_IDLE;
      beat_ff <= 3'h0;
      start_ff <= 3'h0;
      chop_ff <= 1'b0;
      ilv_ff <= 1'b0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      dqs_ff <= 1'b0;
      col_ff <= 3'h0;
      wr_cnt_ff <= 4'h0;
      iws_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      beat_ff <= nxt_beat;
      start_ff <= nxt_start;
      chop_ff <= nxt_chop;
      ilv_ff <= nxt_ilv;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      dqs_ff <= nxt_dqs;
      col_ff <= nxt_col;
      wr_cnt_ff <= nxt_wr_cnt;
      iws_ff <= nxt_iws;
    end
  end

  // stored burst line, cleared at reset so reads are defined
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < BEATS; i++) begin
        line_ff[i] <= '0;
      end
    end else if (line_we) begin
      line_ff[line_addr] <= fifo_data;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dq_out = dq_ff;
  assign dq_oe_out = dq_oe_ff;
  assign dqs_out = dqs_ff;
  assign dqs_oe_out = dq_oe_ff;
  assign beat_col_out = col_ff;
  assign interleaved_out = mr0_ff[MR0_BT_BIT];
  assign burst_len_sel_out = mr0_ff[MR0_BL_LSB +: 2];
  assign dll_reset_pulse_out = dll_pulse_ff;
  assign write_recovery_out = mr0_ff[MR0_WR_LSB +: 3];
  assign pd_fast_exit_out = mr0_ff[MR0_PD_FAST_BIT];
  assign drive_strength_out = {mr1_ff[MR1_DRV_HI_BIT], mr1_ff[MR1_DRV_LO_BIT]};
  assign write_leveling_out = mr1_ff[MR1_WLVL_BIT];
  assign outputs_off_out = mr1_ff[MR1_QOFF_BIT];
  assign internal_write_start_out = iws_ff;

  // dll runs when enabled, stops in self-refresh and in slow-exit power-down
  assign dll_running_out = !mr1_ff[MR1_DLL_DIS_BIT] && !self_refresh_in
                           && !(precharge_pd_in && !mr0_ff[MR0_PD_FAST_BIT]);

endmodule : smb_mode_burst
`default_nettype wire

// ### verif/smb_ctrl_model.sv
// controller model: command pins and write beats
`timescale 1ns/1ps
`default_nettype none
module smb_ctrl_model
  import smb_pkg::*;
(
  input wire logic clock_in,
  input wire logic wr_ready_in,
  output logic cs_n_out,
  output logic [2:0] rcw_out,
  output logic [2:0] bank_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_valid_out
);
  // idle pins from time zero
  initial begin
    cs_n_out = 1'b1;
    rcw_out = 3'h7;
    bank_out = 3'h0;
    addr_out = 14'h0000;
    wr_data_out = 8'h00;
    wr_valid_out = 1'b0;
  end
  // one command cycle, then deselect with inverted pins
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    rcw_out <= rcw;
    bank_out <= ba;
    addr_out <= a;
    @(posedge clock_in);
    cs_n_out <= 1'b1;
    rcw_out <= 3'h7;
    bank_out <= ~ba;
    addr_out <= ~a;
  endtask : issue
  // offer a beat after a random stall; ok tells if taken
  task automatic push(input logic [DATA_W-1:0] d, output logic ok);
    repeat ($urandom_range(1, 0)) @(posedge clock_in);
    @(posedge clock_in);
    wr_valid_out <= 1'b1;
    wr_data_out <= d;
    #1;
    ok = wr_ready_in;
    @(posedge clock_in);
    wr_valid_out <= 1'b0;
    wr_data_out <= ~d;
  endtask : push
endmodule : smb_ctrl_model
`default_nettype wire

// ### verif/smb_mode_burst_asserts.sv
// assertion checker for the mode and burst order logic
`timescale 1ns/1ps
`default_nettype none
module smb_mode_burst_asserts
  import smb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [2:0] bank_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic self_refresh_in,
  input wire logic precharge_pd_in,
  input wire logic dq_oe_out,
  input wire logic dqs_out,
  input wire logic dqs_oe_out,
  input wire logic interleaved_out,
  input wire logic [1:0] burst_len_sel_out,
  input wire logic dll_reset_pulse_out,
  input wire logic dll_running_out,
  input wire logic pd_fast_exit_out,
  input wire logic [1:0] drive_strength_out,
  input wire logic outputs_off_out,
  input wire logic internal_write_start_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // command decodes
  wire logic mrs = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
  wire logic mrs0 = mrs && bank_in == BANK_FIRST_MR;
  wire logic mrs1 = mrs && bank_in == BANK_SECOND_MR;
  wire logic rw = !cs_n_in && ras_n_in && !cas_n_in;
  wire logic wr_c = rw && !we_n_in;
  wire logic chop = burst_len_sel_out == BL_FIXED_CHOP || (burst_len_sel_out == BL_ON_THE_FLY && !addr_in[12]);
  logic dll_dis_ff;  // mirror of the dll disable bit
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) dll_dis_ff <= 1'b0;
    else if (mrs1) dll_dis_ff <= addr_in[MR1_DLL_DIS_BIT];
  end
  sequence rd_chop; rw && we_n_in && !outputs_off_out && chop; endsequence
  sequence rd_full; rw && we_n_in && !outputs_off_out && !chop; endsequence
  sequence wr_late; !internal_write_start_out[*6] ##1 internal_write_start_out; endsequence
  a_mr0_fields: assert property (mrs0 |=> {interleaved_out, burst_len_sel_out, pd_fast_exit_out}
    == {$past(addr_in[3]), $past(addr_in[1:0]), $past(addr_in[12])}) else $error("mr0 load");
  a_mr1_fields: assert property (mrs1 |=> {drive_strength_out, outputs_off_out}
    == {$past(addr_in[5]), $past(addr_in[1]), $past(addr_in[12])}) else $error("mr1 load");
  a_dll_pulse: assert property (mrs0 && addr_in[MR0_DLL_RST_BIT] |-> ##2 dll_reset_pulse_out
    ##1 !dll_reset_pulse_out) else $error("dll reset pulse");
  a_chop_read: assert property (rd_chop |-> ##2 dq_oe_out[*4] ##1 !dq_oe_out[*5])
    else $error("chop read drivers");
  a_full_read: assert property (rd_full |-> ##2 dq_oe_out[*8] ##1 !dq_oe_out)
    else $error("eight read drivers");
  a_strobe_first: assert property ($rose(dq_oe_out) |-> dqs_out && dqs_oe_out ##1 !dqs_out && dqs_oe_out)
    else $error("strobe phase");
  a_wr_chop: assert property (wr_c && burst_len_sel_out == BL_FIXED_CHOP |->
    ##1 !internal_write_start_out[*4] ##1 internal_write_start_out) else $error("chop write start");
  a_wr_eight: assert property (wr_c && burst_len_sel_out != BL_FIXED_CHOP |-> ##1 wr_late)
    else $error("eight write start");
  a_qoff_drivers: assert property (outputs_off_out |-> !dq_oe_out && !dqs_oe_out)
    else $error("drivers on while off");
  a_dll_selfref: assert property (!dll_dis_ff && !precharge_pd_in |-> dll_running_out == !self_refresh_in)
    else $error("dll in self-refresh");
  a_dll_pdown: assert property (!dll_dis_ff && precharge_pd_in && !self_refresh_in
    |-> dll_running_out == pd_fast_exit_out) else $error("dll in power-down");
endmodule : smb_mode_burst_asserts
bind smb_mode_burst smb_mode_burst_asserts u_asserts (.clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
  .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in), .bank_in(bank_in), .addr_in(addr_in),
  .self_refresh_in(self_refresh_in), .precharge_pd_in(precharge_pd_in), .dq_oe_out(dq_oe_out), .dqs_out(dqs_out),
  .dqs_oe_out(dqs_oe_out), .interleaved_out(interleaved_out), .burst_len_sel_out(burst_len_sel_out),
  .dll_reset_pulse_out(dll_reset_pulse_out), .dll_running_out(dll_running_out), .pd_fast_exit_out(pd_fast_exit_out),
  .drive_strength_out(drive_strength_out), .outputs_off_out(outputs_off_out),
  .internal_write_start_out(internal_write_start_out));
`default_nettype wire

// ### verif/test_sdram_mode_burst_order_logic.sv
// self-checking bench for the mode and burst order logic
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_burst_order_logic;
  import smb_pkg::*;
  localparam int DLL_LOCK_CYC = 16;  // shortened lock wait
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sr = 1'b0;
  logic ppd = 1'b0;
  logic bt = 1'b0;  // expected burst type
  logic ch = 1'b0;  // expected chop
  logic cs_n, wv, wr_ready, dq_oe, dqs, dqs_oe, ilv, dllp, dllr, pdf, wlv, qoff, iws;
  logic [2:0] rcw, bank, bcol, wrec;
  logic [1:0] bls, drv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, dq;
  logic [DATA_W-1:0] mem [8];  // expected stored line
  int err_total = 0;
  int samples_checked = 0;
  always #2 clock_in = ~clock_in;
  smb_ctrl_model ctl (.clock_in(clock_in), .wr_ready_in(wr_ready), .cs_n_out(cs_n), .rcw_out(rcw),
    .bank_out(bank), .addr_out(addr), .wr_data_out(wd), .wr_valid_out(wv));
  smb_mode_burst DUT (.clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n), .ras_n_in(rcw[2]),
    .cas_n_in(rcw[1]), .we_n_in(rcw[0]), .bank_in(bank), .addr_in(addr), .self_refresh_in(sr),
    .precharge_pd_in(ppd), .wr_data_in(wd), .wr_valid_in(wv), .wr_ready_out(wr_ready), .dq_out(dq),
    .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(dqs_oe), .beat_col_out(bcol), .interleaved_out(ilv),
    .burst_len_sel_out(bls), .dll_reset_pulse_out(dllp), .dll_running_out(dllr), .write_recovery_out(wrec),
    .pd_fast_exit_out(pdf), .drive_strength_out(drv), .write_leveling_out(wlv), .outputs_off_out(qoff),
    .internal_write_start_out(iws));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // mode register load with spacing
  task automatic mrs(input logic [2:0] ba, input logic [ADDR_W-1:0] a);
    ctl.issue(3'h0, ba, a);
    repeat (3) @(posedge clock_in);  // spacing between set commands
    #1;
  endtask : mrs
  // read burst, every slot but the last four of a chop compared with the expected line
  task automatic rd(input logic [2:0] s, input logic c12, input logic off);
    logic [2:0] col;
    ctl.issue(3'h5, 3'h0, {1'b0, c12, 9'h000, s});
    for (int i = 0; i < BEATS; i++) begin
      @(posedge clock_in);
      #1;
      col = bt ? s ^ 3'(i) : {s[2] ^ i[2], s[1:0] + 2'(i)};
      if (i < 4 || !ch) begin
        check("read col", 16'(bcol), 16'(col));
        check("read data", 16'(dq), 16'(mem[col]));
        check("strobe", 16'(dqs), 16'(i % 2 == 0));
      end
      check("drivers", 16'({dq_oe, dqs_oe}), ((i < 4 || !ch) && !off) ? 16'h3 : 16'h0);
    end
  endtask : rd
  // fill the buffer until refused, then write and drain it
  task automatic wr(input logic [2:0] s, input logic c12, input int lat);
    logic [DATA_W-1:0] d [9];
    logic ok;
    int k;
    for (int j = 0; j < 9; j++) begin
      d[j] = DATA_W'($urandom);
      ctl.push(d[j], ok);
      check("beat taken", 16'(ok), 16'(j < 8));
    end
    ctl.issue(3'h4, 3'h0, {1'b0, c12, 9'h000, s});
    k = 0;
    while (k < 10 && iws !== 1'b1) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    check("write start", 16'(k), 16'(lat));
    for (int j = 0; j < 8; j++) begin
      if (!ch) mem[j] = d[j];  // start column ignored
      else if (j < 4) mem[{s[2], 2'(j)}] = d[j];
    end
    repeat (6) @(posedge clock_in);
    #1;
    check("buffer drained", 16'(wr_ready), 16'h1);
  endtask : wr
  // watchdog against a hang
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial begin
    logic [ADDR_W-1:0] a;
    void'($urandom(32'h0e4d_7cba));
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1;
    check("reset mode", 16'({ilv, bls, wrec, pdf, drv, wlv, qoff}), 16'h0);
    check("reset dll", 16'({wr_ready, dllr}), 16'h3);
    for (int n = 0; n < 6; n++) begin
      a = ADDR_W'($urandom) & 14'h12bb;  // reserved and termination bits zero
      mrs(BANK_SECOND_MR, a);
      check("second reg", 16'({drv, wlv, qoff}), 16'({a[5], a[1], a[7], a[12]}));
    end
    mrs(BANK_SECOND_MR, 14'h0000);
    ctl.issue(3'h0, BANK_FIRST_MR, 14'h0100);
    @(posedge clock_in);
    #1;
    check("dll reset pulse", 16'(dllp), 16'h1);
    @(posedge clock_in);
    #1;
    check("dll reset clear", 16'(dllp), 16'h0);
    repeat (DLL_LOCK_CYC) @(posedge clock_in);  // lock wait after the dll reset
    for (int b = 0; b < 2; b++) begin
      for (int m = 0; m < 4; m++) begin
        bt = b[0];
        ch = (m == 1 || m == 3);
        a = {1'b0, b[0], 3'(m + 2), 5'h00, b[0], 1'b0, m == 3 ? BL_FIXED_CHOP : m == 0 ? BL_FIXED_EIGHT : BL_ON_THE_FLY};
        mrs(BANK_FIRST_MR, a);
        check("first reg", 16'({ilv, bls, wrec, pdf}), 16'({a[3], a[1:0], a[11:9], a[12]}));
        wr(3'($urandom), m >= 2, m == 3 ? 4 : 6);
        rd(3'($urandom), m >= 2, 1'b0);
        @(posedge clock_in);
        ppd <= 1'b1;
        #1;
        check("dll power-down", 16'(dllr), 16'(b));
        @(posedge clock_in);
        ppd <= 1'b0;
        sr <= 1'b1;
        #1;
        check("dll self-refresh", 16'(dllr), 16'h0);
        @(posedge clock_in);
        sr <= 1'b0;
        #1;
        check("dll exit", 16'(dllr), 16'h1);
      end
    end
    mrs(BANK_SECOND_MR, 14'h1000);
    rd(3'h5, 1'b1, 1'b1);
    give_verdict();
  end
endmodule : test_sdram_mode_burst_order_logic
`default_nettype wire
